// ---- bench/dre_host_model.sv ----
// Host model: command and parameter bytes toward the RAM address block
`timescale 1ns/1ps

module dre_host_model (
	input  wire logic              clk,
	input  wire logic              busy,
	output dre_pkg::dre_host_byte_t host_byte
);
	import dre_pkg::*;

	// Idle line at time zero
	initial begin
		host_byte = '{valid: 1'b0, is_data: 1'b0, value: 8'h5a};
	end

	// One byte per call; a released value line shows the inverse, never a stale copy
	task automatic send_byte(input logic is_data, input logic [7:0] value);
		int n;
		n = 0;
		while (!is_data && busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		#1;
		host_byte.valid   = 1'b1;
		host_byte.is_data = is_data;
		host_byte.value   = value;
		@(posedge clk);
		#1;
		host_byte.valid = 1'b0;
		host_byte.value = ~value;
	endtask : send_byte

endmodule : dre_host_model

// ---- bench/testbench.sv ----
// Testbench: address stepping, entry mode, no-op and pattern fill of the RAM address block
`timescale 1ns/1ps

module testbench;
	import dre_pkg::*;

	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic           clk;
	logic           srst;
	dre_host_byte_t host_byte;
	dre_win_t       win;
	logic           busy_reg;
	dre_ram_wr_t    ram_wr_reg;
	logic [5:0]     x_addr_reg;
	logic [8:0]     y_addr_reg;
	dre_entry_t     entry_reg;
	int             err_count = 0;
	int             cmp_count = 0;
	int             cyc = 0;

	dre_ram_addr dre_ram_addr_i (
		.clk(clk), .srst(srst), .host_byte(host_byte), .win(win), .busy_reg(busy_reg),
		.ram_wr_reg(ram_wr_reg), .x_addr_reg(x_addr_reg), .y_addr_reg(y_addr_reg),
		.entry_reg(entry_reg)
	);

	dre_host_model dre_host_model_i (.clk(clk), .busy(busy_reg), .host_byte(host_byte));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard, well above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			report_and_stop();
		end
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic report_and_stop();
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic send(input logic is_data, input logic [7:0] v);
		dre_host_model_i.send_byte(is_data, v);
	endtask : send

	// Lands after the edge so registered outputs are settled
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic set_xy(input logic [5:0] x, input logic [8:0] y);
		send(1'b0, DRE_CMD_SET_X);
		send(1'b1, {2'b11, x});
		tick();
		check(x_addr_reg, x);
		send(1'b0, DRE_CMD_SET_Y);
		send(1'b1, y[7:0]);
		send(1'b1, {7'h7f, y[8]});
		tick();
		check(y_addr_reg, y);
	endtask : set_xy

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		check({x_addr_reg, y_addr_reg}, {DRE_X_RST, DRE_Y_RST});
		check(entry_reg, DRE_ENTRY_RST);
		check({busy_reg, ram_wr_reg.we}, 2'b00);
	endtask : t_reset

	// One data write under entry mode e; red RAM when dir bit 0 is set, for variety
	task automatic step_case(input logic [2:0] e, input logic [5:0] x, input logic [8:0] y,
		input logic [5:0] ex, input logic [8:0] ey);
		send(1'b0, DRE_CMD_ENTRY);
		send(1'b1, {5'h00, e});
		tick();
		check(entry_reg, e);
		set_xy(x, y);
		send(1'b0, e[0] ? DRE_CMD_WR_RED : DRE_CMD_WR_BW);
		send(1'b1, {2'b10, x});
		// The write pulse stands only in the cycle that send returns in
		check({ram_wr_reg.we, ram_wr_reg.red, ram_wr_reg.x, ram_wr_reg.y}, {2'b11 & {1'b1, e[0]},
			x, y});
		check(ram_wr_reg.data, {2'b10, x});
		check({x_addr_reg, y_addr_reg}, {ex, ey});
	endtask : step_case

	// No-op ends the write sequence; the next data byte must be dropped
	task automatic t_nop();
		send(1'b0, DRE_CMD_ENTRY);
		send(1'b1, 8'h03);
		set_xy(6'd3, 9'd6);
		send(1'b0, DRE_CMD_WR_BW);
		send(1'b1, 8'h3c);
		send(1'b0, DRE_CMD_NOP);
		send(1'b1, 8'hc3);
		check(ram_wr_reg.we, 1'b0);
		check({entry_reg, x_addr_reg, y_addr_reg}, {3'b011, 6'd4, 9'd6});
	endtask : t_nop

	// Fill walks the window X first; pattern from first value and step sizes
	task automatic fill(input logic [7:0] c, input logic [7:0] p, input int h, input int wb);
		int n;
		int ncol;
		int col;
		int row;
		logic saw;
		ncol = win.x_end - win.x_start + 1;
		n = 0;
		saw = 1'b0;
		send(1'b0, c);
		send(1'b1, p);
		for (int i = 0; i < 400; i++) begin
			tick();
			saw = saw | busy_reg;
			if (ram_wr_reg.we === 1'b1) begin
				col = n % ncol;
				row = n / ncol;
				check({ram_wr_reg.red, ram_wr_reg.x, ram_wr_reg.y}, {c == DRE_CMD_FILL_RED,
					win.x_start + 6'(col), win.y_start + 9'(row)});
				check(ram_wr_reg.data, (p[7] ^ ((col / wb) % 2 == 1) ^ ((row / h) % 2 == 1)) ?
					DRE_BYTE_ONES : DRE_BYTE_ZEROS);
				n++;
			end
			if (n > 0 && busy_reg === 1'b0) begin
				break;
			end
		end
		check(saw, 1'b1);
		check(n, ncol * (win.y_end - win.y_start + 1));
	endtask : fill

	task automatic t_bad_fill(input logic [7:0] p);
		send(1'b0, DRE_CMD_FILL_BW);
		send(1'b1, p);
		repeat (4) begin
			tick();
			check({busy_reg, ram_wr_reg.we}, 2'b00);
		end
	endtask : t_bad_fill

	task automatic t_fill();
		int hrow[7] = '{8, 16, 32, 64, 128, 256, 296};
		int wbyte[6] = '{1, 2, 4, 8, 16, 22};
		logic [2:0] k;
		win = '{x_start: 6'd0, x_end: 6'd9, y_start: 9'd0, y_end: 9'd8};
		set_xy(6'd9, 9'd20);
		for (int i = 0; i < 7; i++) begin
			k = 3'(i);
			fill(k[0] ? DRE_CMD_FILL_RED : DRE_CMD_FILL_BW, {k[1], k, 1'b0, 3'(i % 6)},
				hrow[i], wbyte[i % 6]);
		end
		t_bad_fill(8'h86);
		t_bad_fill(8'h70);
		check({x_addr_reg, y_addr_reg}, {6'd9, 9'd20});
	endtask : t_fill

	// Main sequence
	initial begin
		srst = 1'b1;
		win = '{x_start: 6'd2, x_end: 6'd4, y_start: 9'd5, y_end: 9'd7};
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		step_case(3'b011, 6'd3, 9'd6, 6'd4, 9'd6);
		step_case(3'b011, 6'd4, 9'd6, 6'd2, 9'd7);
		step_case(3'b000, 6'd3, 9'd6, 6'd2, 9'd6);
		step_case(3'b000, 6'd2, 9'd6, 6'd4, 9'd5);
		step_case(3'b001, 6'd4, 9'd5, 6'd2, 9'd7);
		step_case(3'b110, 6'd3, 9'd6, 6'd3, 9'd7);
		step_case(3'b110, 6'd3, 9'd7, 6'd2, 9'd5);
		step_case(3'b101, 6'd4, 9'd5, 6'd2, 9'd7);
		step_case(3'b010, 6'd2, 9'd7, 6'd4, 9'd5);
		t_nop();
		t_fill();
		report_and_stop();
	end

endmodule : testbench

// ---- src/dre_addr_step.sv ----
// Address stepper: next X/Y address after a RAM write, wrapped at the window edges
`timescale 1ns/1ps

module dre_addr_step (
	input  dre_pkg::dre_entry_t entry,
	input  dre_pkg::dre_win_t   win,
	input  wire logic [5:0]     x_cur,
	input  wire logic [8:0]     y_cur,
	output logic [5:0]          x_next,
	output logic [8:0]          y_next
);
	import dre_pkg::*;

	// ************************************************************
	// One axis step, wrap flag in the top bit
	// ************************************************************
	function automatic logic [9:0] step_axis(
		input logic [8:0] v,
		input logic [8:0] s,
		input logic [8:0] e,
		input logic       inc
	);
		logic [9:0] r;
		if (inc) begin
			r = (v == e) ? {1'b1, s} : {1'b0, 9'(v + 9'h001)};
		end else begin
			r = (v == s) ? {1'b1, e} : {1'b0, 9'(v - 9'h001)};
		end
		return r;
	endfunction : step_axis

	logic [9:0] xs;
	logic [9:0] ys;

	// Active axis steps; the other steps only when the active one wraps
	always_comb begin
		xs = step_axis({3'h0, x_cur}, {3'h0, win.x_start}, {3'h0, win.x_end},
			entry.dir[0]);
		ys = step_axis(y_cur, win.y_start, win.y_end, entry.dir[1]);
		if (!entry.axis) begin
			x_next = xs[5:0];
			y_next = xs[9] ? ys[8:0] : y_cur;
		end else begin
			y_next = ys[8:0];
			x_next = ys[9] ? xs[5:0] : x_cur;
		end
	end

endmodule : dre_addr_step

// ---- src/dre_pkg.sv ----
// Package: command codes, field layout, reset values and carrier types of the RAM address block
package dre_pkg;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [7:0] DRE_CMD_ENTRY    = 8'h11;
	localparam logic [7:0] DRE_CMD_WR_BW    = 8'h24;
	localparam logic [7:0] DRE_CMD_WR_RED   = 8'h26;
	localparam logic [7:0] DRE_CMD_FILL_RED = 8'h46;
	localparam logic [7:0] DRE_CMD_FILL_BW  = 8'h47;
	localparam logic [7:0] DRE_CMD_SET_X    = 8'h4e;
	localparam logic [7:0] DRE_CMD_SET_Y    = 8'h4f;
	localparam logic [7:0] DRE_CMD_NOP      = 8'h7f;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int DRE_ENTRY_AXIS_BIT = 2;
	localparam int DRE_ENTRY_DIR_LSB  = 0;
	localparam int DRE_FILL_FIRST_BIT = 7;
	localparam int DRE_FILL_H_LSB     = 4;
	localparam int DRE_FILL_W_LSB     = 0;
	localparam int DRE_Y_HIGH_BIT     = 0;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [2:0] DRE_ENTRY_RST  = 3'h3;
	localparam logic [5:0] DRE_X_RST      = 6'h00;
	localparam logic [8:0] DRE_Y_RST      = 9'h000;
	localparam logic [2:0] DRE_FILL_H_RST = 3'h0;
	localparam logic       DRE_FIRST_RST  = 1'b0;

	// Fill data for a set and a clear step
	localparam logic [7:0] DRE_BYTE_ONES  = 8'hff;
	localparam logic [7:0] DRE_BYTE_ZEROS = 8'h00;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic       valid;
		logic       is_data;
		logic [7:0] value;
	} dre_host_byte_t;

	typedef struct packed {
		logic       axis;
		logic [1:0] dir;
	} dre_entry_t;

	typedef struct packed {
		logic [5:0] x_start;
		logic [5:0] x_end;
		logic [8:0] y_start;
		logic [8:0] y_end;
	} dre_win_t;

	typedef struct packed {
		logic       we;
		logic       red;
		logic [5:0] x;
		logic [8:0] y;
		logic [7:0] data;
	} dre_ram_wr_t;

	typedef enum logic [3:0] {
		DRE_IDLE      = 4'b0000,
		DRE_GET_X     = 4'b0001,
		DRE_GET_YLO   = 4'b0010,
		DRE_GET_YHI   = 4'b0011,
		DRE_GET_ENTRY = 4'b0100,
		DRE_GET_FILL  = 4'b0101,
		DRE_WRITE     = 4'b0110,
		DRE_FILL      = 4'b0111
	} dre_phase_t;

	typedef struct packed {
		dre_phase_t  phase;
		dre_entry_t  entry;
		logic [5:0]  x;
		logic [8:0]  y;
		logic [7:0]  y_low;
		logic        busy;
		logic        wr_red;
		dre_ram_wr_t wr;
		logic        fill_red;
		logic        first;
		logic [8:0]  rows_m1;
		logic [4:0]  cols_m1;
		dre_win_t    win;
		logic [5:0]  fx;
		logic [8:0]  fy;
		logic [4:0]  col_cnt;
		logic [8:0]  row_cnt;
		logic        x_phase;
		logic        y_phase;
	} dre_state_t;

endpackage : dre_pkg

// ---- src/dre_ram_addr.sv ----
// RAM address counters, data entry mode and regular pattern fill of the display RAM
//
// Function
// - 0x47 plus one byte starts B/W fill
// - Height bits 6:4 select rows per step
// - Width bits 2:0 select columns per step
// - Red fill uses the same width code
// - Busy high through fill; host waits
// - 0x4E loads six-bit X counter, reset zero
// - 0x4F loads nine-bit Y from two bytes
// - 0x7F changes nothing, ends RAM write
// - 0x11 sets axis bit and direction bits
// - Direction bit one increments after write
// - Direction bit zero decrements after write
// - Bit 0 drives X, bit 1 drives Y
// - Axis bit selects which address advances
// - Write address wraps at the RAM window edges
// - Bit 7 gives first step value, alternating
// - 0x46 starts red fill, same layout
`timescale 1ns/1ps

module dre_ram_addr (
	input  wire logic              clk,
	input  wire logic              srst,
	input  dre_pkg::dre_host_byte_t host_byte,
	input  dre_pkg::dre_win_t      win,
	output logic                   busy_reg,
	output dre_pkg::dre_ram_wr_t   ram_wr_reg,
	output logic [5:0]             x_addr_reg,
	output logic [8:0]             y_addr_reg,
	output dre_pkg::dre_entry_t    entry_reg
);
	import dre_pkg::*;

	// ************************************************************
	// Step size decoding
	// ************************************************************

	// Rows per step minus one; top bit flags an invalid code
	function automatic logic [9:0] height_m1(input logic [2:0] code);
		case (code)
			3'h0:    height_m1 = 10'h007;
			3'h1:    height_m1 = 10'h00f;
			3'h2:    height_m1 = 10'h01f;
			3'h3:    height_m1 = 10'h03f;
			3'h4:    height_m1 = 10'h07f;
			3'h5:    height_m1 = 10'h0ff;
			3'h6:    height_m1 = 10'h127;
			default: height_m1 = 10'h200;
		endcase
	endfunction : height_m1

	// Byte columns per step minus one (X unit is eight pixels); bit 5 flags invalid
	function automatic logic [5:0] width_m1(input logic [2:0] code);
		case (code)
			3'h0:    width_m1 = 6'h00;
			3'h1:    width_m1 = 6'h01;
			3'h2:    width_m1 = 6'h03;
			3'h3:    width_m1 = 6'h07;
			3'h4:    width_m1 = 6'h0f;
			3'h5:    width_m1 = 6'h15;
			default: width_m1 = 6'h20;
		endcase
	endfunction : width_m1

	dre_state_t st_reg;
	dre_state_t st_next;
	logic [5:0] step_x;
	logic [8:0] step_y;
	logic [9:0] hdec;
	logic [5:0] wdec;

	// ************************************************************
	// Address stepper for host data writes
	// ************************************************************
	dre_addr_step u_step (
		.entry  (st_reg.entry),
		.win    (win),
		.x_cur  (st_reg.x),
		.y_cur  (st_reg.y),
		.x_next (step_x),
		.y_next (step_y)
	);

	// ************************************************************
	// Next-state logic
	// ************************************************************

	// Bytes arriving during a fill are dropped: the host must poll busy first
	always_comb begin
		st_next       = st_reg;
		st_next.wr.we = 1'b0;
		hdec          = height_m1(host_byte.value[DRE_FILL_H_LSB +: 3]);
		wdec          = width_m1(host_byte.value[DRE_FILL_W_LSB +: 3]);
		if (st_reg.phase == DRE_FILL) begin
			st_next.wr.we   = 1'b1;
			st_next.wr.red  = st_reg.fill_red;
			st_next.wr.x    = st_reg.fx;
			st_next.wr.y    = st_reg.fy;
			st_next.wr.data = (st_reg.first ^ st_reg.x_phase ^ st_reg.y_phase) ?
				DRE_BYTE_ONES : DRE_BYTE_ZEROS;
			if (st_reg.fx == st_reg.win.x_end) begin
				st_next.fx      = st_reg.win.x_start;
				st_next.col_cnt = 5'h00;
				st_next.x_phase = 1'b0;
				if (st_reg.fy == st_reg.win.y_end) begin
					st_next.phase = DRE_IDLE;
					st_next.busy  = 1'b0;
				end else begin
					st_next.fy = 9'(st_reg.fy + 9'h001);
					if (st_reg.row_cnt == st_reg.rows_m1) begin
						st_next.row_cnt = 9'h000;
						st_next.y_phase = ~st_reg.y_phase;
					end else begin
						st_next.row_cnt = 9'(st_reg.row_cnt + 9'h001);
					end
				end
			end else begin
				st_next.fx = 6'(st_reg.fx + 6'h01);
				if (st_reg.col_cnt == st_reg.cols_m1) begin
					st_next.col_cnt = 5'h00;
					st_next.x_phase = ~st_reg.x_phase;
				end else begin
					st_next.col_cnt = 5'(st_reg.col_cnt + 5'h01);
				end
			end
		end else if (host_byte.valid && !host_byte.is_data) begin
			// Any command ends a RAM write; unknown ones leave all else as is
			case (host_byte.value)
				DRE_CMD_ENTRY:    st_next.phase = DRE_GET_ENTRY;
				DRE_CMD_SET_X:    st_next.phase = DRE_GET_X;
				DRE_CMD_SET_Y:    st_next.phase = DRE_GET_YLO;
				DRE_CMD_FILL_BW:  st_next.phase = DRE_GET_FILL;
				DRE_CMD_FILL_RED: st_next.phase = DRE_GET_FILL;
				DRE_CMD_WR_BW:    st_next.phase = DRE_WRITE;
				DRE_CMD_WR_RED:   st_next.phase = DRE_WRITE;
				default:          st_next.phase = DRE_IDLE;
			endcase
			st_next.fill_red = (host_byte.value == DRE_CMD_FILL_RED);
			st_next.wr_red   = (host_byte.value == DRE_CMD_WR_RED);
		end else if (host_byte.valid) begin
			case (st_reg.phase)
				DRE_GET_X: begin
					st_next.x     = host_byte.value[5:0];
					st_next.phase = DRE_IDLE;
				end
				DRE_GET_YLO: begin
					st_next.y_low = host_byte.value;
					st_next.phase = DRE_GET_YHI;
				end
				DRE_GET_YHI: begin
					st_next.y     = {host_byte.value[DRE_Y_HIGH_BIT], st_reg.y_low};
					st_next.phase = DRE_IDLE;
				end
				DRE_GET_ENTRY: begin
					st_next.entry.axis = host_byte.value[DRE_ENTRY_AXIS_BIT];
					st_next.entry.dir  = host_byte.value[DRE_ENTRY_DIR_LSB +: 2];
					st_next.phase      = DRE_IDLE;
				end
				DRE_GET_FILL: begin
					// Invalid step codes drop the fill rather than guess a size
					if (hdec[9] || wdec[5]) begin
						st_next.phase = DRE_IDLE;
					end else begin
						st_next.phase   = DRE_FILL;
						st_next.busy    = 1'b1;
						st_next.first   = host_byte.value[DRE_FILL_FIRST_BIT];
						st_next.rows_m1 = hdec[8:0];
						st_next.cols_m1 = wdec[4:0];
						st_next.win     = win;
						st_next.fx      = win.x_start;
						st_next.fy      = win.y_start;
						st_next.col_cnt = 5'h00;
						st_next.row_cnt = 9'h000;
						st_next.x_phase = 1'b0;
						st_next.y_phase = 1'b0;
					end
				end
				DRE_WRITE: begin
					st_next.wr.we   = 1'b1;
					st_next.wr.red  = st_reg.wr_red;
					st_next.wr.x    = st_reg.x;
					st_next.wr.y    = st_reg.y;
					st_next.wr.data = host_byte.value;
					st_next.x       = step_x;
					st_next.y       = step_y;
				end
				default: st_next.phase = DRE_IDLE;
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg          <= '0;
			st_reg.phase    <= DRE_IDLE;
			st_reg.entry    <= dre_entry_t'(DRE_ENTRY_RST);
			st_reg.x        <= DRE_X_RST;
			st_reg.y        <= DRE_Y_RST;
			st_reg.first    <= DRE_FIRST_RST;
			st_reg.rows_m1  <= {6'h00, DRE_FILL_H_RST};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state flops
	assign busy_reg   = st_reg.busy;
	assign ram_wr_reg = st_reg.wr;
	assign x_addr_reg = st_reg.x;
	assign y_addr_reg = st_reg.y;
	assign entry_reg  = st_reg.entry;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	busy_fill_a: assert property ((st_reg.phase == DRE_FILL) |-> busy_reg)
		else $error("busy low during fill");
	fill_start_a: assert property ((st_reg.phase == DRE_GET_FILL) && host_byte.valid
		&& host_byte.is_data && !hdec[9] && !wdec[5] |=> busy_reg ##1 ram_wr_reg.we)
		else $error("fill did not start");
	x_load_a: assert property ((st_reg.phase == DRE_GET_X) && host_byte.valid
		&& host_byte.is_data |=> x_addr_reg == $past(host_byte.value[5:0]))
		else $error("x counter not loaded");
	// Host paces parameter bytes one idle cycle apart
	y_load_a: assert property ((st_reg.phase == DRE_GET_YLO) && host_byte.valid
		&& host_byte.is_data ##2 (host_byte.valid && host_byte.is_data)
		|=> y_addr_reg == {$past(host_byte.value[0]), $past(host_byte.value, 3)})
		else $error("y counter not loaded");
	nop_keep_a: assert property (host_byte.valid && !host_byte.is_data
		&& host_byte.value == DRE_CMD_NOP && !busy_reg
		|=> $stable(x_addr_reg) && $stable(y_addr_reg) && $stable(entry_reg)
		&& st_reg.phase == DRE_IDLE)
		else $error("nop changed state");
	entry_load_a: assert property ((st_reg.phase == DRE_GET_ENTRY)
		&& host_byte.valid && host_byte.is_data |=> entry_reg == $past(host_byte.value[2:0]))
		else $error("entry mode not loaded");
	x_inc_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && !entry_reg.axis && entry_reg.dir[0] && x_addr_reg != win.x_end
		|=> x_addr_reg == 6'($past(x_addr_reg) + 6'h01) && $stable(y_addr_reg))
		else $error("x did not increment");
	x_dec_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && !entry_reg.axis && !entry_reg.dir[0]
		&& x_addr_reg != win.x_start |=> x_addr_reg == 6'($past(x_addr_reg) - 6'h01))
		else $error("x did not decrement");
	y_axis_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && entry_reg.axis && entry_reg.dir[1] && y_addr_reg != win.y_end
		|=> y_addr_reg == 9'($past(y_addr_reg) + 9'h001) && $stable(x_addr_reg))
		else $error("y axis did not step");
	x_wrap_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && !entry_reg.axis && entry_reg.dir[0]
		&& x_addr_reg == win.x_end |=> x_addr_reg == $past(win.x_start)
		&& y_addr_reg != $past(y_addr_reg) || $past(win.y_start == win.y_end))
		else $error("x wrap failed");
	x_low_wrap_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && !entry_reg.axis && !entry_reg.dir[0]
		&& x_addr_reg == win.x_start |=> x_addr_reg == $past(win.x_end))
		else $error("x low wrap failed");
	y_wrap_a: assert property ((st_reg.phase == DRE_WRITE) && host_byte.valid
		&& host_byte.is_data && entry_reg.axis && entry_reg.dir[1]
		&& y_addr_reg == win.y_end |=> y_addr_reg == $past(win.y_start))
		else $error("y wrap failed");

	// Counters and mode move only on their own parameter or a data write
	x_keep_a: assert property (!$stable(x_addr_reg) |-> $past((st_reg.phase == DRE_GET_X
		|| st_reg.phase == DRE_WRITE) && host_byte.valid && host_byte.is_data))
		else $error("x counter moved unasked");
	y_keep_a: assert property (!$stable(y_addr_reg) |-> $past((st_reg.phase == DRE_GET_YHI
		|| st_reg.phase == DRE_WRITE) && host_byte.valid && host_byte.is_data))
		else $error("y counter moved unasked");
	entry_keep_a: assert property (!$stable(entry_reg) |-> $past(host_byte.valid
		&& host_byte.is_data && (st_reg.phase == DRE_GET_ENTRY)))
		else $error("entry mode moved unasked");
	host_wr_a: assert property (ram_wr_reg.we && !busy_reg && !$past(busy_reg) |->
		$past((st_reg.phase == DRE_WRITE) && host_byte.valid && host_byte.is_data)
		&& ram_wr_reg.data == $past(host_byte.value) && ram_wr_reg.x == $past(x_addr_reg)
		&& ram_wr_reg.y == $past(y_addr_reg))
		else $error("stray or misplaced RAM write");

	// Fill walk: corner start, X fastest, busy drops with the last write
	fill_keep_a: assert property ((st_reg.phase == DRE_FILL) |=> $stable(x_addr_reg)
		&& $stable(y_addr_reg))
		else $error("counters moved during fill");
	fill_inside_a: assert property (ram_wr_reg.we && busy_reg |->
		ram_wr_reg.x >= st_reg.win.x_start && ram_wr_reg.x <= st_reg.win.x_end
		&& ram_wr_reg.y >= st_reg.win.y_start && ram_wr_reg.y <= st_reg.win.y_end)
		else $error("fill wrote outside window");
	fill_first_a: assert property ((st_reg.phase == DRE_GET_FILL) && host_byte.valid
		&& host_byte.is_data && !hdec[9] && !wdec[5] ##2 ram_wr_reg.we
		|-> ram_wr_reg.data == ($past(host_byte.value[7], 2) ? DRE_BYTE_ONES
		: DRE_BYTE_ZEROS))
		else $error("first step value wrong");
	bad_fill_a: assert property ((st_reg.phase == DRE_GET_FILL) && host_byte.valid
		&& host_byte.is_data && (hdec[9] || wdec[5]) |=> !busy_reg
		&& st_reg.phase == DRE_IDLE)
		else $error("invalid fill code accepted");
	fill_corner_a: assert property ($rose(busy_reg) |=> ram_wr_reg.we
		&& ram_wr_reg.x == st_reg.win.x_start && ram_wr_reg.y == st_reg.win.y_start)
		else $error("fill did not start at window corner");
	fill_order_a: assert property (ram_wr_reg.we && busy_reg |=> ram_wr_reg.we
		&& (ram_wr_reg.x == 6'($past(ram_wr_reg.x) + 6'h01) && $stable(ram_wr_reg.y)
		|| ram_wr_reg.x == st_reg.win.x_start
		&& ram_wr_reg.y == 9'($past(ram_wr_reg.y) + 9'h001)))
		else $error("fill order broken");
	fill_end_a: assert property ($fell(busy_reg) |-> ram_wr_reg.we
		&& ram_wr_reg.x == st_reg.win.x_end && ram_wr_reg.y == st_reg.win.y_end)
		else $error("busy fell before last fill write");

endmodule : dre_ram_addr
